/* File: readout_pkg.sv */
// shared constants and types for the linear array readout link
package readout_pkg;

    localparam int SECTIONS = 2;
    localparam int STAGES = 768;
    localparam int SERIAL_PIXELS = 1536;
    localparam int SERIAL_CLOCKS = 1537;
    localparam int PARALLEL_CLOCKS = 769;
    localparam int RESET_CLOCKS = 18;

    localparam int PIX_W = 12;
    localparam int SCENE_W = 8;
    localparam int HT_W = 16;
    localparam int IDX_W = 10;
    localparam int CNT_W = 11;

    localparam logic [PIX_W-1:0] PIX_MAX = 12'hfff;
    localparam logic [HT_W-1:0] HT_MAX = 16'hffff;
    localparam logic [4:0] RESET_LOAD = 5'h12;

    // timing at the 25 MHz system clock
    localparam int CLK_PERIOD_NS = 40;
    localparam int CHARGE_WAIT_NS = 20000;
    localparam int CHARGE_WAIT_CYC = (CHARGE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_W = 10;

    // shift clock enable every SHIFT_DIV system clocks (1 MHz)
    localparam int SHIFT_DIV = 25;
    localparam int DIV_W = 5;

    typedef enum logic [1:0]
    {
        CTL_IDLE = 2'b00,
        CTL_ARM = 2'b01,
        CTL_READ = 2'b10,
        CTL_WAIT = 2'b11
    } ctrl_state_t;

endpackage : readout_pkg

/* File: readout_link_if.sv */
// link between the array sensor end and the readout controller end
`timescale 1ns/1ps
interface readout_link_if;
    import readout_pkg::*;

    logic shiftClockLower;
    logic shiftClockUpper;
    logic startTokenLower;
    logic startTokenUpper;
    logic freezeLower;
    logic freezeUpper;
    logic chainOutLower;
    logic chainOutUpper;
    logic [PIX_W-1:0] pixelOutLower;
    logic pixelOutLowerOeN;
    logic [PIX_W-1:0] pixelOutUpper;
    logic pixelOutUpperOeN;

    modport sensor
    (
        input shiftClockLower,
        input shiftClockUpper,
        input startTokenLower,
        input startTokenUpper,
        input freezeLower,
        input freezeUpper,
        output chainOutLower,
        output chainOutUpper,
        output pixelOutLower,
        output pixelOutLowerOeN,
        output pixelOutUpper,
        output pixelOutUpperOeN
    );

    modport ctrl
    (
        output shiftClockLower,
        output shiftClockUpper,
        output startTokenLower,
        output startTokenUpper,
        output freezeLower,
        output freezeUpper,
        input chainOutLower,
        input chainOutUpper,
        input pixelOutLower,
        input pixelOutLowerOeN,
        input pixelOutUpper,
        input pixelOutUpperOeN
    );

endinterface : readout_link_if

/* File: linear_array_sensor.sv */
// two-section linear array sensor end: token shift, hold and pixel output
`timescale 1ns/1ps
module linear_array_sensor
(
    input wire logic mclk,
    input wire logic reset,
    readout_link_if.sensor link,
    output logic [readout_pkg::IDX_W-1:0] scenePixelLower,
    input wire logic [readout_pkg::SCENE_W-1:0] sceneLevelLower,
    output logic [readout_pkg::IDX_W-1:0] scenePixelUpper,
    input wire logic [readout_pkg::SCENE_W-1:0] sceneLevelUpper
);
    import readout_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // per-section views of the link

    logic [SECTIONS-1:0] shiftEn;
    logic [SECTIONS-1:0] startIn;
    logic [SECTIONS-1:0] freezeIn;
    logic [SCENE_W-1:0] sceneLvl [SECTIONS];

    logic chainOut_r [SECTIONS];
    logic oeN_r [SECTIONS];
    logic [PIX_W-1:0] pixelOut_r [SECTIONS];
    logic [IDX_W-1:0] pixIdx_r [SECTIONS];

    assign shiftEn = {link.shiftClockUpper, link.shiftClockLower};
    assign startIn = {link.startTokenUpper, link.startTokenLower};
    assign freezeIn = {link.freezeUpper, link.freezeLower};
    assign sceneLvl[0] = sceneLevelLower;
    assign sceneLvl[1] = sceneLevelUpper;

    assign link.chainOutLower = chainOut_r[0];
    assign link.chainOutUpper = chainOut_r[1];
    assign link.pixelOutLower = pixelOut_r[0];
    assign link.pixelOutUpper = pixelOut_r[1];
    assign link.pixelOutLowerOeN = oeN_r[0];
    assign link.pixelOutUpperOeN = oeN_r[1];
    assign scenePixelLower = pixIdx_r[0];
    assign scenePixelUpper = pixIdx_r[1];

    ////////////////////////////////////////////////////////////////////////////////
    // held charge times scene level, clipped at full scale

    function automatic logic [PIX_W-1:0] pixelValue
    (
        input logic [SCENE_W-1:0] level,
        input logic [HT_W-1:0] held
    );
        logic [SCENE_W+HT_W-1:0] prod;
        prod = level * held;
        if (prod > {{(SCENE_W+HT_W-PIX_W){1'b0}}, PIX_MAX})
        begin
            pixelValue = PIX_MAX;
        end
        else
        begin
            pixelValue = prod[PIX_W-1:0];
        end
    endfunction : pixelValue

    ////////////////////////////////////////////////////////////////////////////////
    // one identical section per half of the array

    generate
        for (genvar s = 0; s < SECTIONS; s++)
        begin : g_section
            logic [STAGES-1:0] stage_r;
            logic [STAGES-1:0] stage_nxt;
            logic freezePrev_r;
            logic resetting_r;
            logic [4:0] resetLeft_r;
            logic [HT_W-1:0] intTime_r;
            logic [HT_W-1:0] heldTime_r;
            logic capture;
            logic holdEvt;
            logic activeNxt;

            // shifts, count steps and outputs below wait for this section's own clock; freeze detect, hold and clears do not
            assign capture = shiftEn[s] & startIn[s];
            assign holdEvt = freezeIn[s] & ~freezePrev_r;
            assign stage_nxt = {stage_r[STAGES-2:0], startIn[s]};
            assign activeNxt = |stage_nxt;

            // token shift register
            always_ff @(posedge mclk)
            begin
                if (reset)
                begin
                    stage_r <= '0;
                end
                else if (shiftEn[s])
                begin
                    stage_r <= stage_nxt;
                end
            end

            // chain output: token sits in the last stage from edge 768 to 769
            always_ff @(posedge mclk)
            begin
                if (reset)
                begin
                    chainOut_r[s] <= 1'b0;
                end
                else if (shiftEn[s])
                begin
                    chainOut_r[s] <= stage_r[STAGES-2];
                end
            end

            // hold edge detect on the freeze input
            always_ff @(posedge mclk)
            begin
                if (reset)
                begin
                    freezePrev_r <= 1'b0;
                end
                else
                begin
                    freezePrev_r <= freezeIn[s];
                end
            end

            // one shared held time stands for every sample at once
            always_ff @(posedge mclk)
            begin
                if (reset)
                begin
                    heldTime_r <= '0;
                end
                else if (holdEvt)
                begin
                    heldTime_r <= intTime_r;
                end
            end

            // integrator reset period, counted in section clocks from capture
            always_ff @(posedge mclk)
            begin
                if (reset)
                begin
                    resetting_r <= 1'b0;
                    resetLeft_r <= '0;
                end
                else if (capture)
                begin
                    resetting_r <= 1'b1;
                    resetLeft_r <= RESET_LOAD - 5'h01;
                end
                else if (holdEvt)
                begin
                    resetting_r <= 1'b1;
                end
                else if (shiftEn[s] && resetting_r)
                begin
                    if (resetLeft_r == 5'h00)
                    begin
                        resetting_r <= 1'b0;
                    end
                    else
                    begin
                        resetLeft_r <= resetLeft_r - 5'h01;
                    end
                end
            end

            // integration time, in section clocks, saturating
            always_ff @(posedge mclk)
            begin
                if (reset)
                begin
                    intTime_r <= '0;
                end
                else if (holdEvt || resetting_r)
                begin
                    intTime_r <= '0;
                end
                else if (shiftEn[s] && intTime_r != HT_MAX)
                begin
                    intTime_r <= intTime_r + 16'h0001;
                end
            end

            // output phase: drive one held pixel per clock, float otherwise
            always_ff @(posedge mclk)
            begin
                if (reset)
                begin
                    oeN_r[s] <= 1'b1;
                    pixelOut_r[s] <= '0;
                    pixIdx_r[s] <= '0;
                end
                else if (shiftEn[s])
                begin
                    oeN_r[s] <= ~activeNxt;
                    if (activeNxt)
                    begin
                        pixelOut_r[s] <= pixelValue(sceneLvl[s], heldTime_r);
                        pixIdx_r[s] <= pixIdx_r[s] + 10'h001;
                    end
                    else
                    begin
                        pixelOut_r[s] <= '0;
                        pixIdx_r[s] <= '0;
                    end
                end
            end
        end
    endgenerate

endmodule : linear_array_sensor

/* File: readout_controller.sv */
// readout controller end: shift clocks, start and freeze, pixel capture
`timescale 1ns/1ps
module readout_controller
(
    input wire logic mclk,
    input wire logic reset,
    readout_link_if.ctrl link,
    input wire logic frameReq,
    input wire logic serialMode,
    output logic busy,
    output logic pixelValid,
    output logic [readout_pkg::CNT_W-1:0] pixelNum,
    output logic [readout_pkg::PIX_W-1:0] pixelLower,
    output logic [readout_pkg::PIX_W-1:0] pixelUpper,
    output logic frameDone
);
    import readout_pkg::*;

    ctrl_state_t state_r;
    logic [DIV_W-1:0] divCnt_r;
    logic tick;
    logic serial_r;
    logic [CNT_W-1:0] pulseCnt_r;
    logic [CNT_W-1:0] lastPulse;
    logic [WAIT_W-1:0] waitCnt_r;
    logic shift_r;
    logic shiftUp_r;
    logic sample_r;
    logic start_r;
    logic startNxt;
    logic serialNxt;
    logic startUp_r;
    logic freezeLo_r;
    logic freezeUp_r;

    assign link.shiftClockLower = shift_r;
    assign link.shiftClockUpper = shiftUp_r;
    assign link.startTokenLower = start_r;
    assign link.startTokenUpper = startUp_r;
    assign link.freezeLower = freezeLo_r;
    assign link.freezeUpper = freezeUp_r;

    assign tick = (divCnt_r == DIV_W'(SHIFT_DIV - 1));
    assign lastPulse = serial_r ? CNT_W'(SERIAL_CLOCKS) : CNT_W'(PARALLEL_CLOCKS);

    ////////////////////////////////////////////////////////////////////////////////
    // free-running shift clock divider
    always_ff @(posedge mclk)
    begin
        if (reset || tick)
        begin
            divCnt_r <= '0;
        end
        else
        begin
            divCnt_r <= divCnt_r + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequencing
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state_r <= CTL_IDLE;
            serial_r <= 1'b0;
            pulseCnt_r <= '0;
            waitCnt_r <= '0;
            frameDone <= 1'b0;
        end
        else
        begin
            frameDone <= 1'b0;
            unique case (state_r)
                CTL_IDLE:
                begin
                    if (frameReq)
                    begin
                        serial_r <= serialMode;
                        state_r <= CTL_ARM;
                    end
                end
                CTL_ARM:
                begin
                    if (tick)
                    begin
                        pulseCnt_r <= 11'h001;
                        state_r <= CTL_READ;
                    end
                end
                CTL_READ:
                begin
                    if (tick)
                    begin
                        pulseCnt_r <= pulseCnt_r + 11'h001;
                        if (pulseCnt_r + 11'h001 == lastPulse)
                        begin
                            waitCnt_r <= '0;
                            state_r <= CTL_WAIT;
                        end
                    end
                end
                CTL_WAIT:
                begin
                    if (waitCnt_r == WAIT_W'(CHARGE_WAIT_CYC - 1))
                    begin
                        frameDone <= 1'b1;
                        state_r <= CTL_IDLE;
                    end
                    else
                    begin
                        waitCnt_r <= waitCnt_r + 10'h001;
                    end
                end
            endcase
        end
    end

    // both section clocks tick together in either mode
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            shift_r <= 1'b0;
            shiftUp_r <= 1'b0;
            sample_r <= 1'b0;
        end
        else
        begin
            shift_r <= tick && (state_r == CTL_ARM || state_r == CTL_READ);
            shiftUp_r <= tick && (state_r == CTL_ARM || state_r == CTL_READ);
            sample_r <= shift_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // start and freeze: raised at request (serial upper start: from chainOutLower), dropped after one shift clock
    always_comb
    begin
        // mode of the frame being armed, so a mode change cannot leak a stray upper start
        serialNxt = (state_r == CTL_IDLE && frameReq) ? serialMode : serial_r;
        startNxt = start_r;
        if (state_r == CTL_IDLE && frameReq)
        begin
            startNxt = 1'b1;
        end
        else if (shift_r)
        begin
            startNxt = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            start_r <= 1'b0;
            freezeLo_r <= 1'b0;
            freezeUp_r <= 1'b0;
            startUp_r <= 1'b0;
        end
        else
        begin
            start_r <= startNxt;
            freezeLo_r <= startNxt;
            freezeUp_r <= startNxt;
            // serial: registered copy still spans the next shift clock
            startUp_r <= serialNxt ? link.chainOutLower : startNxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pixel capture one cycle after each shift clock
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pixelValid <= 1'b0;
            pixelNum <= '0;
            pixelLower <= '0;
            pixelUpper <= '0;
        end
        else
        begin
            pixelValid <= sample_r && pulseCnt_r != '0 &&
                pulseCnt_r <= (serial_r ? CNT_W'(SERIAL_PIXELS) : CNT_W'(STAGES));
            pixelNum <= pulseCnt_r - 11'h001;
            if (sample_r)
            begin
                pixelLower <= link.pixelOutLowerOeN ? '0 : link.pixelOutLower;
                pixelUpper <= link.pixelOutUpperOeN ? '0 : link.pixelOutUpper;
            end
        end
    end

    assign busy = (state_r != CTL_IDLE);

endmodule : readout_controller

/* File: readout_properties.sv */
// link checker: token timing, output enables and start spacing on the readout link
`timescale 1ns/1ps
module readout_properties
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic shiftClockLower,
    input wire logic shiftClockUpper,
    input wire logic startTokenLower,
    input wire logic startTokenUpper,
    input wire logic freezeLower,
    input wire logic freezeUpper,
    input wire logic chainOutLower,
    input wire logic chainOutUpper,
    input wire logic [readout_pkg::PIX_W-1:0] pixelOutLower,
    input wire logic pixelOutLowerOeN,
    input wire logic [readout_pkg::PIX_W-1:0] pixelOutUpper,
    input wire logic pixelOutUpperOeN
);
    import readout_pkg::*;

    logic [CNT_W-1:0] cntLo_r;
    logic [CNT_W-1:0] cntUp_r;
    logic [15:0] idleLo_r;
    logic lastStartLo_r;
    logic doneLo_r;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

////////////////////////////////////////////////////////////
    // pulse count since capture, parked on the terminating pulse
    always_ff @(posedge mclk)
    begin
        if (reset)
            cntLo_r <= 11'h000;
        else if (shiftClockLower && startTokenLower)
            cntLo_r <= 11'h001;
        else if (shiftClockLower && cntLo_r != 11'h000 && cntLo_r != 11'h301)
            cntLo_r <= cntLo_r + 11'h001;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            cntUp_r <= 11'h000;
        else if (shiftClockUpper && startTokenUpper)
            cntUp_r <= 11'h001;
        else if (shiftClockUpper && cntUp_r != 11'h000 && cntUp_r != 11'h301)
            cntUp_r <= cntUp_r + 11'h001;
    end

    // saturating, so a long idle gap cannot wrap into a short one
    always_ff @(posedge mclk)
    begin
        if (reset || !pixelOutLowerOeN)
            idleLo_r <= 16'h0000;
        else if (idleLo_r != 16'hffff)
            idleLo_r <= idleLo_r + 16'h0001;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            doneLo_r <= 1'b0;
        else if (cntLo_r == 11'h301)
            doneLo_r <= 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            lastStartLo_r <= 1'b0;
        else if (shiftClockLower)
            lastStartLo_r <= startTokenLower;
    end

////////////////////////////////////////////////////////////
    AST_LO_FIRST: assert property ($fell(pixelOutLowerOeN) |-> cntLo_r == 11'h001)
        else $error("lower output enabled away from the capturing pulse");
    AST_LO_CHAIN_RISE: assert property ($rose(chainOutLower) |-> cntLo_r == 11'h300)
        else $error("lower chain output rose on the wrong pulse");
    AST_LO_END: assert property ($rose(pixelOutLowerOeN) |-> cntLo_r == 11'h301 && $fell(chainOutLower))
        else $error("lower section did not end on its terminating pulse");
    AST_LO_STEP: assert property (($changed(chainOutLower) || $changed(pixelOutLowerOeN)) |-> $past(shiftClockLower))
        else $error("lower section moved without a shift pulse");
    AST_LO_FLOAT: assert property (pixelOutLowerOeN |-> pixelOutLower == 12'h000)
        else $error("lower pixel value shown while floating");
    AST_UP_CHAIN_RISE: assert property ($rose(chainOutUpper) |-> cntUp_r == 11'h300)
        else $error("upper chain output rose on the wrong pulse");
    AST_UP_END: assert property ($rose(pixelOutUpperOeN) |-> cntUp_r == 11'h301 && $fell(chainOutUpper))
        else $error("upper section did not end on its terminating pulse");
    AST_UP_FLOAT: assert property (pixelOutUpperOeN |-> pixelOutUpper == 12'h000)
        else $error("upper pixel value shown while floating");
    AST_START_SINGLE: assert property (shiftClockLower && startTokenLower |-> !lastStartLo_r)
        else $error("start held over two shift pulses");
    AST_FREEZE_TIE: assert property (freezeLower == startTokenLower && (freezeUpper == startTokenUpper || freezeUpper == freezeLower))
        else $error("freeze not following its start");
    AST_CHARGE_WAIT: assert property (shiftClockLower && startTokenLower && doneLo_r |-> idleLo_r >= 16'(CHARGE_WAIT_CYC - 1))
        else $error("next start came before the charge transfer wait");
endmodule : readout_properties

/* File: linear_array_readout_sequencer_tb.sv */
// self-checking bench: sensor end and controller end joined over the readout link
`timescale 1ns/1ps
module linear_array_readout_sequencer_tb;
    import readout_pkg::*;

    logic mclk;
    logic reset;
    logic frameReq;
    logic serialMode;
    logic busy;
    logic pixelValid;
    logic [CNT_W-1:0] pixelNum;
    logic [PIX_W-1:0] pixelLower;
    logic [PIX_W-1:0] pixelUpper;
    logic frameDone;
    logic [IDX_W-1:0] scenePixelLower;
    logic [IDX_W-1:0] scenePixelUpper;
    logic [SCENE_W-1:0] sceneLevelLower;
    logic [SCENE_W-1:0] sceneLevelUpper;
    int miscompares;
    int comparisons;
    int cycles;

    readout_link_if link();

    // different light patterns per section, so swapped sections show up
    assign sceneLevelLower = scenePixelLower[0] ? 8'hff : 8'h00;
    assign sceneLevelUpper = scenePixelUpper[1] ? 8'hff : 8'h00;

    linear_array_sensor linear_array_sensor_inst
    (
        .mclk(mclk), .reset(reset), .link(link.sensor),
        .scenePixelLower(scenePixelLower), .sceneLevelLower(sceneLevelLower),
        .scenePixelUpper(scenePixelUpper), .sceneLevelUpper(sceneLevelUpper)
    );

    readout_controller readout_controller_inst
    (
        .mclk(mclk), .reset(reset), .link(link.ctrl), .frameReq(frameReq),
        .serialMode(serialMode), .busy(busy), .pixelValid(pixelValid), .pixelNum(pixelNum),
        .pixelLower(pixelLower), .pixelUpper(pixelUpper), .frameDone(frameDone)
    );

    readout_properties readout_properties_inst
    (
        .mclk(mclk), .reset(reset),
        .shiftClockLower(link.shiftClockLower), .shiftClockUpper(link.shiftClockUpper),
        .startTokenLower(link.startTokenLower), .startTokenUpper(link.startTokenUpper),
        .freezeLower(link.freezeLower), .freezeUpper(link.freezeUpper),
        .chainOutLower(link.chainOutLower), .chainOutUpper(link.chainOutUpper),
        .pixelOutLower(link.pixelOutLower), .pixelOutLowerOeN(link.pixelOutLowerOeN),
        .pixelOutUpper(link.pixelOutUpper), .pixelOutUpperOeN(link.pixelOutUpperOeN)
    );

    always #20 mclk = ~mclk;

////////////////////////////////////////////////////////////
    task automatic check_word(input logic [PIX_W-1:0] got, input logic [PIX_W-1:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_flag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_flag

    task automatic finish_test;
        if (miscompares == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    // one frame; dark frames only judge unlit pixels, their exposure is unknown
    task automatic run_frame(input logic ser, input logic lit, input logic poke);
        int n;
        int waitCnt;
        int idx;
        n = 0;
        waitCnt = 0;
        frameReq = 1'b1;
        serialMode = ser;
        @(negedge mclk);
        frameReq = 1'b0;
        @(negedge mclk);
        check_flag(busy, 1'b1);
        while (frameDone !== 1'b1 && waitCnt < 41000)
        begin
            @(negedge mclk);
            waitCnt++;
            frameReq = poke && n == 100;
            if (pixelValid === 1'b1)
            begin
                idx = (ser && n >= STAGES) ? n - STAGES : n;
                if ((!ser || n < STAGES) && (lit || !idx[0]))
                    check_word(pixelLower, (lit && idx[0]) ? PIX_MAX : 12'h000);
                if ((!ser || n >= STAGES) && (lit || !idx[1]))
                    check_word(pixelUpper, (lit && idx[1]) ? PIX_MAX : 12'h000);
                check_word({1'b0, pixelNum}, 12'(n));
                n++;
            end
        end
        check_word(12'(n), ser ? 12'(SERIAL_PIXELS) : 12'(STAGES));
    endtask : run_frame

////////////////////////////////////////////////////////////
    task automatic test_first_frame;
        check_flag(link.pixelOutLowerOeN, 1'b1);
        check_flag(link.chainOutUpper, 1'b0);
        run_frame(1'b0, 1'b0, 1'b0);
    endtask : test_first_frame

    // a request in mid-frame must not start a second frame
    task automatic test_busy_refusal;
        run_frame(1'b0, 1'b1, 1'b1);
        repeat (3) @(negedge mclk);
        check_flag(busy, 1'b0);
        check_flag(pixelValid, 1'b0);
    endtask : test_busy_refusal

    task automatic test_serial_chain;
        run_frame(1'b1, 1'b1, 1'b0);
        check_flag(link.pixelOutUpperOeN, 1'b1);
    endtask : test_serial_chain

    // ceiling: two parallel frames and one serial frame with margin
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            miscompares++;
            finish_test();
        end
    end

    initial
    begin
        mclk = 1'b0;
        reset = 1'b1;
        frameReq = 1'b0;
        serialMode = 1'b0;
        miscompares = 0;
        comparisons = 0;
        cycles = 0;
        repeat (10) @(negedge mclk);
        reset = 1'b0;
        test_first_frame();
        test_busy_refusal();
        test_serial_chain();
        finish_test();
    end
endmodule : linear_array_readout_sequencer_tb
